//--- verilog/rx_port_paged_config_regs.sv
`timescale 1ns/1ps
// What this block does
// - 8-bit equalizer error limit, reset one; re-adapt when error count exceeds it.
// - addresses 0x44 to 0x49 are reserved, read-only, read zero.
// - capability bit 4, reset zero, gates encoder CRC error flag reporting.
// - embedded type count 00 forwards every long packet as raw video.
// - count 1, 2 or 3 sends that many first long packets as embedded.
// - those first lines use the embedded type code, reset 0x12, as type.
// - substitution only in raw input mode, never in CSI-formatted input.
// - page select steers accesses to 0x4D-0x7F and 0xD0-0xDF.
// - read-page bit 4 picks port 0 or port 1 for paged reads.
// - read page defaults zero locally, arriving port number over back channel.
// - write enables bit 0 and 1; paged writes broadcast to enabled blocks.
// - write enables default zero locally, own port only over back channel.
// - physical link index bit 6 reads zero locally, arriving port remotely.
// - each access source keeps its own page-select state.
// - receive status at 0x4D is banked per port via page select.
// - bit 6 of first paged status reports the selected read page.
module rx_port_paged_config_regs
  import rx_page_pkg::*;
#(
  parameter int ERR_CNT_W = 8
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // register access from local i2c or back channel
  input wire reg_req_t req_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  // paged register blocks of the two receive ports
  output paged_req_t paged_req_out,
  input wire logic [7:0] paged_rdata0_in,
  input wire logic [7:0] paged_rdata1_in,
  // equalizer error monitor
  input wire logic [ERR_CNT_W-1:0] link_err_count_in,
  input wire logic err_window_done_in,
  output logic eq_readapt_out,
  // encoder crc error reporting
  input wire logic encoder_crc_err_in,
  output logic encoder_crc_flag_out,
  // line data type substitution
  input wire logic raw_input_mode_in,
  input wire logic frame_start_in,
  input wire logic long_packet_in,
  input wire logic [5:0] raw_type_code_in,
  output logic [5:0] line_type_code_out,
  output line_kind_t line_kind_out
);

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [7:0] eq_error_limit_ff;
  logic [7:0] link_capability_ff;
  logic [1:0] embedded_type_count_ff;
  logic [5:0] embedded_type_code_ff;
  // index 0 is the local i2c source, 1 and 2 the back channel of port 0 and 1
  page_sel_t sel_ff [3];

  // ************************************************************
  // request decode
  // ************************************************************
  // strobes are decoded once here so every register sees the same address match
  logic wr;
  logic rd;
  logic [1:0] src;
  logic wr_limit;
  logic wr_cap;
  logic wr_emb;
  logic wr_sel;

  // local i2c owns copy 0; a back-channel access owns the copy of its own port
  function automatic logic [1:0] source_of(input logic remote, input logic link_idx);
    if (!remote) begin
      source_of = 2'h0;
    end else if (link_idx) begin
      source_of = 2'h2;
    end else begin
      source_of = 2'h1;
    end
  endfunction

  function automatic logic in_paged(input logic [7:0] a);
    in_paged = (a >= ADDR_PAGE_A_FIRST && a <= ADDR_PAGE_A_LAST) ||
               (a >= ADDR_PAGE_B_FIRST && a <= ADDR_PAGE_B_LAST);
  endfunction

  function automatic logic in_reserved(input logic [7:0] a);
    in_reserved = a >= ADDR_RSVD_FIRST && a <= ADDR_RSVD_LAST;
  endfunction

  // writes into the reserved gap match no strobe and are dropped
  function automatic logic hits(input logic [7:0] a, input logic [7:0] target);
    hits = a == target;
  endfunction

  assign wr = req_in.valid && req_in.write;
  assign rd = req_in.valid && !req_in.write;
  assign src = source_of(req_in.remote, req_in.link_idx);
  assign wr_limit = wr && hits(req_in.addr, ADDR_EQ_ERROR_LIMIT);
  assign wr_cap = wr && hits(req_in.addr, ADDR_LINK_CAPABILITY);
  assign wr_emb = wr && hits(req_in.addr, ADDR_EMBEDDED_TYPE_CTRL);
  assign wr_sel = wr && hits(req_in.addr, ADDR_PORT_PAGE_SELECT);

  // ************************************************************
  // fixed configuration registers
  // ************************************************************
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      eq_error_limit_ff <= RST_EQ_ERROR_LIMIT;
    end else if (wr_limit) begin
      // a written zero is stored; software is expected never to do so
      eq_error_limit_ff <= req_in.wdata;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link_capability_ff <= RST_LINK_CAPABILITY;
    end else if (wr_cap) begin
      // reserved bits are kept and read back, only bit 4 acts
      link_capability_ff <= req_in.wdata;
    end
  end

  // count and code share one byte; a single write updates both together
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      embedded_type_count_ff <= RST_EMBEDDED_TYPE_COUNT;
    end else if (wr_emb) begin
      embedded_type_count_ff <= req_in.wdata[EMB_COUNT_LSB +: 2];
    end
  end

  // a new code takes effect on the next long packet, even in mid-frame
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      embedded_type_code_ff <= RST_EMBEDDED_TYPE_CODE;
    end else if (wr_emb) begin
      embedded_type_code_ff <= req_in.wdata[5:0];
    end
  end

  // ************************************************************
  // per-source page select
  // ************************************************************
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sel_ff[0] <= '{read_port: 1'b0, write_en: 2'h0};
      sel_ff[1] <= '{read_port: 1'b0, write_en: 2'h1};
      sel_ff[2] <= '{read_port: 1'b1, write_en: 2'h2};
    end else if (wr_sel) begin
      // only the requesting source's copy changes; reserved bits dropped
      sel_ff[src].read_port <= req_in.wdata[SEL_READ_BIT];
      sel_ff[src].write_en <= req_in.wdata[1:0];
    end
  end

  // ************************************************************
  // paged access routing
  // ************************************************************
  // combinational so a broadcast write reaches both blocks on the same edge
  always_comb begin
    paged_req_out.valid = req_in.valid && in_paged(req_in.addr);
    paged_req_out.write = req_in.write;
    paged_req_out.write_en = sel_ff[src].write_en;
    paged_req_out.read_port = sel_ff[src].read_port;
    paged_req_out.addr = req_in.addr;
    paged_req_out.wdata = req_in.wdata;
  end

  // ************************************************************
  // read data
  // ************************************************************
  // page select image: physical index, read page, write enables, reserved zero
  function automatic logic [7:0] sel_image(input page_sel_t s, input logic phys);
    sel_image = RSVD_READ_VALUE;
    sel_image[SEL_PHYS_BIT] = phys;
    sel_image[SEL_READ_BIT] = s.read_port;
    sel_image[1:0] = s.write_en;
  endfunction

  logic [7:0] nxt_rdata;
  logic [7:0] page_rd;
  logic phys_idx;
  // the local interface always reads index zero, whatever port it steers
  assign phys_idx = req_in.remote && req_in.link_idx;

  always_comb begin
    // a port with writes disabled still answers reads when it is the read page
    page_rd = sel_ff[src].read_port ? paged_rdata1_in : paged_rdata0_in;
    nxt_rdata = RSVD_READ_VALUE;
    if (hits(req_in.addr, ADDR_EQ_ERROR_LIMIT)) begin
      nxt_rdata = eq_error_limit_ff;
    end else if (in_reserved(req_in.addr)) begin
      nxt_rdata = RSVD_READ_VALUE;
    end else if (hits(req_in.addr, ADDR_LINK_CAPABILITY)) begin
      nxt_rdata = link_capability_ff;
    end else if (hits(req_in.addr, ADDR_EMBEDDED_TYPE_CTRL)) begin
      nxt_rdata = {embedded_type_count_ff, embedded_type_code_ff};
    end else if (hits(req_in.addr, ADDR_PORT_PAGE_SELECT)) begin
      nxt_rdata = sel_image(sel_ff[src], phys_idx);
    end else if (in_paged(req_in.addr)) begin
      nxt_rdata = page_rd;
      // the block's own bit 6 is replaced, so the page shown is the one chosen
      if (hits(req_in.addr, ADDR_RX_STATUS)) begin
        nxt_rdata[STS_PAGE_BIT] = sel_ff[src].read_port;
      end
    end
  end

  // one pulse per read; the data holds so a slow host may fetch it late
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= rd;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= 8'h00;
    end else if (rd) begin
      rdata_out <= nxt_rdata;
    end
  end

  // ************************************************************
  // equalizer and crc reporting
  // ************************************************************
  localparam int CMP_W = (ERR_CNT_W > 8) ? ERR_CNT_W : 8;

  // both sides are widened first, so a narrow counter never truncates the limit
  function automatic logic over_limit(input logic [ERR_CNT_W-1:0] count,
                                      input logic [7:0] limit);
    over_limit = CMP_W'(count) > CMP_W'(limit);
  endfunction

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      eq_readapt_out <= 1'b0;
    end else begin
      // one-cycle pulse per error window that ended over the limit
      eq_readapt_out <= err_window_done_in && over_limit(link_err_count_in, eq_error_limit_ff);
    end
  end

  // only the report is masked; the error itself still reaches the counters
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      encoder_crc_flag_out <= 1'b0;
    end else begin
      encoder_crc_flag_out <= encoder_crc_err_in &&
        link_capability_ff[CAP_CRC_FLAG_BIT];
    end
  end

  // ************************************************************
  // data type substitution
  // ************************************************************
  // saturates at the largest count the field can ask for, so it never wraps
  localparam logic [1:0] LINE_CNT_MAX = 2'h3;
  logic [1:0] line_cnt_ff;
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      line_cnt_ff <= 2'h0;
    end else if (frame_start_in) begin
      line_cnt_ff <= 2'h0;
    end else if (long_packet_in && line_cnt_ff != LINE_CNT_MAX) begin
      line_cnt_ff <= line_cnt_ff + 2'h1;
    end
  end

  logic embed_now;
  // only raw input lines are rewritten; csi input carries its own types
  assign embed_now = raw_input_mode_in && line_cnt_ff < embedded_type_count_ff;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      line_type_code_out <= 6'h00;
    end else if (long_packet_in) begin
      if (embed_now) begin
        line_type_code_out <= embedded_type_code_ff;
      end else begin
        line_type_code_out <= raw_type_code_in;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      line_kind_out <= LINE_RAW;
    end else if (long_packet_in) begin
      if (embed_now) begin
        line_kind_out <= LINE_EMBED;
      end else begin
        line_kind_out <= LINE_RAW;
      end
    end
  end

endmodule

//--- verilog/rx_page_pkg.sv
package rx_page_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_EQ_ERROR_LIMIT = 8'h43;
  localparam logic [7:0] ADDR_RSVD_FIRST = 8'h44;
  localparam logic [7:0] ADDR_RSVD_LAST = 8'h49;
  localparam logic [7:0] ADDR_LINK_CAPABILITY = 8'h4a;
  localparam logic [7:0] ADDR_EMBEDDED_TYPE_CTRL = 8'h4b;
  localparam logic [7:0] ADDR_PORT_PAGE_SELECT = 8'h4c;
  localparam logic [7:0] ADDR_PAGE_A_FIRST = 8'h4d;
  localparam logic [7:0] ADDR_PAGE_A_LAST = 8'h7f;
  localparam logic [7:0] ADDR_PAGE_B_FIRST = 8'hd0;
  localparam logic [7:0] ADDR_PAGE_B_LAST = 8'hdf;
  localparam logic [7:0] ADDR_RX_STATUS = 8'h4d;

  // ************************************************************
  // reset values and field positions
  // ************************************************************
  localparam logic [7:0] RST_EQ_ERROR_LIMIT = 8'h01;
  localparam logic [7:0] RST_LINK_CAPABILITY = 8'h00;
  localparam logic [1:0] RST_EMBEDDED_TYPE_COUNT = 2'h0;
  localparam logic [5:0] RST_EMBEDDED_TYPE_CODE = 6'h12;
  localparam logic [7:0] RSVD_READ_VALUE = 8'h00;
  localparam int CAP_CRC_FLAG_BIT = 4;
  localparam int EMB_COUNT_LSB = 6;
  localparam int SEL_READ_BIT = 4;
  localparam int SEL_PHYS_BIT = 6;
  localparam int STS_PAGE_BIT = 6;

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic       read_port;
    logic [1:0] write_en;
  } page_sel_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       remote;
    logic       link_idx;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [1:0] write_en;
    logic       read_port;
    logic [7:0] addr;
    logic [7:0] wdata;
  } paged_req_t;

  typedef enum logic [1:0] {
    LINE_EMBED,
    LINE_RAW
  } line_kind_t;

endpackage

//--- dv/rx_cfg_asserts.sv
`timescale 1ns/1ps
module rx_cfg_asserts
  import rx_page_pkg::*;
#(
  parameter int ERR_CNT_W = 8
) (
  // clock, reset, register side
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire reg_req_t req_in,
  input wire logic [7:0] rdata_out,
  input wire logic rvalid_out,
  // paged blocks and side functions
  input wire paged_req_t paged_req_out,
  input wire logic [7:0] paged_rdata0_in,
  input wire logic [7:0] paged_rdata1_in,
  input wire logic [ERR_CNT_W-1:0] link_err_count_in,
  input wire logic err_window_done_in,
  input wire logic eq_readapt_out,
  input wire logic encoder_crc_err_in,
  input wire logic encoder_crc_flag_out,
  input wire logic raw_input_mode_in,
  input wire logic long_packet_in,
  input wire line_kind_t line_kind_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_rd(a);
    req_in.valid && !req_in.write && req_in.addr == a;
  endsequence
  property p_rvalid; rvalid_out == $past(req_in.valid && !req_in.write); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer pulse wrong");
  property p_rsvd;
    req_in.valid && !req_in.write && req_in.addr inside {[8'h44:8'h49]} |=> rdata_out == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
  property p_readapt;
    eq_readapt_out |-> $past(err_window_done_in) && $past(link_err_count_in) != 0;
  endproperty
  a_readapt: assert property (p_readapt) else $error("readapt without cause");
  property p_crc; encoder_crc_flag_out |-> $past(encoder_crc_err_in); endproperty
  a_crc: assert property (p_crc) else $error("crc flag without error");
  property p_raw_only;
    long_packet_in && !raw_input_mode_in |=> line_kind_out == LINE_RAW;
  endproperty
  a_raw_only: assert property (p_raw_only) else $error("embedded outside raw mode");
  property p_paged;
    paged_req_out.valid == (req_in.valid && req_in.addr inside {[8'h4d:8'h7f], [8'hd0:8'hdf]});
  endproperty
  a_paged: assert property (p_paged) else $error("paged range decode wrong");
  property p_pass;
    paged_req_out.valid |->
      paged_req_out.addr == req_in.addr && paged_req_out.wdata == req_in.wdata;
  endproperty
  a_pass: assert property (p_pass) else $error("paged request not passed on");
  property p_sel;
    s_rd(8'h4c) |=> (rdata_out & 8'hac) == 8'h00 &&
      rdata_out[6] == $past(req_in.remote && req_in.link_idx);
  endproperty
  a_sel: assert property (p_sel) else $error("page select readback wrong");
  property p_page_rd;
    req_in.valid && !req_in.write && req_in.addr inside {[8'h4e:8'h7f]}
      |=> rdata_out == $past(paged_req_out.read_port ? paged_rdata1_in : paged_rdata0_in);
  endproperty
  a_page_rd: assert property (p_page_rd) else $error("paged read from wrong block");
  property p_sts; s_rd(8'h4d) |=> rdata_out[6] == $past(paged_req_out.read_port); endproperty
  a_sts: assert property (p_sts) else $error("status page bit wrong");
endmodule
bind rx_port_paged_config_regs rx_cfg_asserts #(.ERR_CNT_W(ERR_CNT_W)) u_chk (.*);

//--- dv/rx_port_blocks_model.sv
`timescale 1ns/1ps
module rx_port_blocks_model
  import rx_page_pkg::*;
(
  input wire logic sys_clk_in,
  input wire paged_req_t req_in,
  output logic [7:0] rdata0_out,
  output logic [7:0] rdata1_out
);
  logic [7:0] mem0 [256];
  logic [7:0] mem1 [256];
  initial for (int i = 0; i < 256; i++) begin
    mem0[i] = 8'(i);
    mem1[i] = ~8'(i);
  end
  always @(posedge sys_clk_in) begin
    if (req_in.valid && req_in.write && req_in.write_en[0])
      mem0[req_in.addr] <= req_in.wdata;
    if (req_in.valid && req_in.write && req_in.write_en[1])
      mem1[req_in.addr] <= req_in.wdata;
  end
  // an idle bus shows flipped data, so a stale value never passes
  assign rdata0_out = req_in.valid ? mem0[req_in.addr] : ~mem0[req_in.addr];
  assign rdata1_out = req_in.valid ? mem1[req_in.addr] : ~mem1[req_in.addr];
endmodule

//--- dv/rx_port_paged_config_regs_tb_top.sv
`timescale 1ns/1ps
module rx_port_paged_config_regs_tb_top;
  import rx_page_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  reg_req_t req = '0;
  paged_req_t preq;
  logic [7:0] rd0, rd1, rdata, cnt = 8'h00, d, e, lim;
  logic rvalid, readapt, flag, done = 1'b0, crc = 1'b0, raw = 1'b0, fs = 1'b0, lp = 1'b0;
  logic [5:0] rcode = 6'h00, code, emb;
  line_kind_t kind;
  int mismatches = 0;
  int samples_checked = 0;
  always #25 sys_clk_in = ~sys_clk_in;
  rx_port_paged_config_regs #(.ERR_CNT_W(8)) DUT (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .req_in(req), .rdata_out(rdata), .rvalid_out(rvalid), .paged_req_out(preq),
    .paged_rdata0_in(rd0), .paged_rdata1_in(rd1), .link_err_count_in(cnt),
    .err_window_done_in(done), .eq_readapt_out(readapt), .encoder_crc_err_in(crc),
    .encoder_crc_flag_out(flag), .raw_input_mode_in(raw), .frame_start_in(fs),
    .long_packet_in(lp), .raw_type_code_in(rcode), .line_type_code_out(code),
    .line_kind_out(kind));
  rx_port_blocks_model u_blk (.sys_clk_in(sys_clk_in), .req_in(preq), .rdata0_out(rd0),
    .rdata1_out(rd1));
  task chk(logic [7:0] got, logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] exp_line(logic m, int n, int k, logic [5:0] em, logic [5:0] r);
    return (m && k < n) ? {LINE_EMBED, em} : {LINE_RAW, r};
  endfunction
  task acc(logic w, logic rem, logic idx, logic [7:0] a, logic [7:0] dat);
    @(posedge sys_clk_in) req <= '{1'b1, w, rem, idx, a, dat};
    @(posedge sys_clk_in) req.valid <= 1'b0;
  endtask
  task wr(logic [7:0] a, logic [7:0] dat);
    acc(1'b1, 1'b0, 1'b0, a, dat);
  endtask
  task rd(logic rem, logic idx, logic [7:0] a, logic [7:0] exp);
    acc(1'b0, rem, idx, a, 8'h00);
    #1 chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask
  // pulses {frame start, window done, crc error, long packet} for one cycle
  task step(logic [3:0] s, logic [7:0] c);
    @(posedge sys_clk_in) {fs, done, crc, lp} <= s;
    cnt <= c;
    rcode <= 6'($urandom);
    @(posedge sys_clk_in) {fs, done, crc, lp} <= 4'h0;
    #1;
  endtask
  task finish_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    mismatches++;
    finish_test();
  end
  initial begin
    void'($urandom(59370));
    repeat (3) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    rd(0, 0, 8'h43, 8'h01);
    for (int a = 8'h44; a <= 8'h49; a++) begin
      wr(8'(a), 8'($urandom));
      rd(0, 0, 8'(a), 8'h00);
    end
    rd(0, 0, 8'h4a, 8'h00);
    rd(0, 0, 8'h4b, 8'h12);
    rd(0, 0, 8'h4c, 8'h00);
    rd(1, 0, 8'h4c, 8'h01);
    rd(1, 1, 8'h4c, 8'h52);
    $display("test reset done");
    wr(8'h4c, 8'hff);
    rd(0, 0, 8'h4c, 8'h13);
    rd(1, 1, 8'h4c, 8'h52);
    d = 8'($urandom);
    e = 8'($urandom);
    wr(8'h60, d);
    wr(8'h4c, 8'h11);
    wr(8'h60, e);
    rd(0, 0, 8'h60, d);
    rd(0, 0, 8'h4d, 8'hf2);
    wr(8'h4c, 8'h00);
    rd(0, 0, 8'h60, e);
    rd(0, 0, 8'h4d, 8'h0d);
    rd(0, 0, 8'hd0, 8'hd0);
    rd(0, 0, 8'h7f, 8'h7f);
    rd(0, 0, 8'h80, 8'h00);
    acc(1, 1, 1, 8'h61, d);
    wr(8'h4c, 8'h10);
    rd(0, 0, 8'h61, d);
    $display("test paging done");
    lim = 8'(1 + $urandom % 254);
    wr(8'h43, lim);
    rd(0, 0, 8'h43, lim);
    step(4'h4, lim);
    chk({7'h00, readapt}, 8'h00);
    step(4'h4, lim + 8'h01);
    chk({7'h00, readapt}, 8'h01);
    step(4'h2, 8'h00);
    chk({7'h00, flag}, 8'h00);
    wr(8'h4a, 8'h10);
    step(4'h2, 8'h00);
    chk({7'h00, flag}, 8'h01);
    $display("test monitors done");
    for (int m = 0; m < 2; m++) begin
      for (int n = 0; n < 4; n++) begin
        @(posedge sys_clk_in) raw <= m[0];
        emb = 6'($urandom);
        wr(8'h4b, {2'(n), emb});
        step(4'h8, 8'h00);
        for (int k = 0; k < 4; k++) begin
          step(4'h1, 8'h00);
          chk({kind, code}, exp_line(m[0], n, k, emb, rcode));
        end
      end
    end
    $display("test lines done");
    finish_test();
  end
endmodule
